// file: rtl/hcr_pkg.sv
/*
 * Shared constants and types of the challenge/response digest block:
 * command locations, reset values, hash constants, state and command carriers.
 * Assumes a byte-wide command-location port driven by a host interface engine.
 */
`default_nettype none
package hcr_pkg;
   localparam logic [7:0] LOC_SUBCLASS = 8'h3E;
   localparam logic [7:0] LOC_BLKSEL = 8'h3F;
   localparam logic [7:0] LOC_BUF_FIRST = 8'h40;
   localparam logic [7:0] LOC_BUF_LAST = 8'h5F;
   localparam logic [7:0] LOC_CHAL_CSUM = 8'h54;
   localparam logic [7:0] LOC_BLK_CSUM = 8'h60;
   localparam logic [7:0] LOC_ACCESS = 8'h61;
   localparam int BUF_BYTES = 32;
   localparam int CHAL_BYTES = 20;
   localparam int KEY_BYTES = 16;
   localparam int KEY_OFS = 12;
   localparam logic [7:0] ACCESS_KEY = 8'h00;
   localparam logic [7:0] ACCESS_AUTH = 8'h01;
   localparam logic [7:0] SUBCLASS_KEY = 8'h70;
   localparam logic [7:0] BLOCK_KEY = 8'h00;
   localparam logic [7:0] BLOCK_AUTH_LOCKED = 8'h00;
   localparam logic [7:0] ACCESS_RST = 8'hFF;
   localparam logic [7:0] SUBCLASS_RST = 8'h00;
   localparam logic [7:0] BLKSEL_RST = 8'hFF;
   localparam logic [127:0] KEY_DEFAULT = 128'h0123456789ABCDEFFEDCBA987654321;
   localparam logic [159:0] SHA_IV = 160'h67452301EFCDAB8998BADCFE10325476C3D2E1F0;
   localparam logic [7:0] IPAD = 8'h36;
   localparam logic [7:0] OPAD = 8'h5C;
   localparam logic [7:0] PAD_MARK = 8'h80;
   localparam logic [63:0] MSG_BITS = 64'h00000000000002A0;
   localparam logic [6:0] ROUND_LAST = 7'h4F;
   localparam logic [31:0] K0 = 32'h5A827999;
   localparam logic [31:0] K1 = 32'h6ED9EBA1;
   localparam logic [31:0] K2 = 32'h8F1BBCDC;
   localparam logic [31:0] K3 = 32'hCA62C1D6;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOAD = 3'b010,
      ST_RUN = 3'b100
   } hcr_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hcr_cmd_s;

   typedef struct packed {
      hcr_state_e st;
      logic [BUF_BYTES-1:0][7:0] buffer;
      logic [127:0] key;
      logic [7:0] access;
      logic [7:0] subclass;
      logic [7:0] blksel;
      logic [7:0] rdata;
      logic done;
      logic [159:0] h;
      logic [159:0] work;
      logic [511:0] w;
      logic [6:0] rnd;
      logic [1:0] blk;
      logic [159:0] inner;
   } hcr_state_s;
endpackage : hcr_pkg
`default_nettype wire

// file: rtl/hcr_responder.sv
/*
 * Keyed-hash challenge responder: command-location buffer, key programming
 * and an iterative one-round-per-cycle SHA-1 engine run as HMAC.
 * Assumes CMD comes from an interface engine on CLK and UNLOCKED is the
 * lock state of the surrounding gauge logic, also on CLK.
 */
`default_nettype none
module hcr_responder (
   input wire logic CLK,
   input wire logic RST,
   input wire hcr_pkg::hcr_cmd_s CMD,
   input wire logic UNLOCKED,
   output logic [7:0] CMD_RDATA,
   output logic BUSY,
   output logic DIGEST_READY
);
   import hcr_pkg::*;

   hcr_state_s s_reg;
   hcr_state_s s_next;

   function automatic logic [7:0] csum(input logic [BUF_BYTES-1:0][7:0] b, input int n);
      logic [7:0] sum;
      sum = 8'h00;
      for (int i = 0; i < BUF_BYTES; i++) begin
         if (i < n) begin
            sum = sum + b[i];
         end
      end
      return 8'hFF - sum;
   endfunction : csum

   // block 0/2: padded key xor ipad/opad; block 1/3: 20-byte tail with padding
   function automatic logic [511:0] msg_block(input logic [1:0] idx, input logic [127:0] key,
         input logic [BUF_BYTES-1:0][7:0] b, input logic [159:0] inner);
      logic [511:0] m;
      logic [7:0] v;
      m = '0;
      for (int i = 0; i < 64; i++) begin
         v = 8'h00;
         if (!idx[0]) begin
            if (i < KEY_BYTES) begin
               v = key[127-8*i -: 8];
            end
            v = v ^ (idx[1] ? OPAD : IPAD);
         end else if (i < CHAL_BYTES) begin
            v = idx[1] ? inner[159-8*i -: 8] : b[i];
         end else if (i == CHAL_BYTES) begin
            v = PAD_MARK;
         end else if (i >= 56) begin
            v = MSG_BITS[63-8*(i-56) -: 8];
         end
         m[511-8*i -: 8] = v;
      end
      return m;
   endfunction : msg_block

   function automatic logic [31:0] rol(input logic [31:0] x, input int n);
      return (x << n) | (x >> (32 - n));
   endfunction : rol

   logic key_mode;
   logic auth_mode;
   logic in_buf;
   logic [4:0] bidx;
   logic [31:0] a;
   logic [31:0] b;
   logic [31:0] c;
   logic [31:0] d;
   logic [31:0] e;
   logic [31:0] f;
   logic [31:0] k;
   logic [31:0] t;
   logic [31:0] w0;
   logic [31:0] wn;
   logic key_sum_ok;
   logic chal_sum_ok;
   logic [159:0] h_sum;

   always_comb begin
      // key path needs unlocked, 0x00 access, subclass 0x70, block 0x00
      key_mode = UNLOCKED && s_reg.access == ACCESS_KEY && s_reg.subclass == SUBCLASS_KEY
         && s_reg.blksel == BLOCK_KEY;
      auth_mode = (UNLOCKED && s_reg.access == ACCESS_AUTH)
         || (!UNLOCKED && s_reg.blksel == BLOCK_AUTH_LOCKED);
      in_buf = CMD.addr >= LOC_BUF_FIRST && CMD.addr <= LOC_BUF_LAST;
      bidx = CMD.addr[4:0];
      // sums use the buffer as it stands before this write
      key_sum_ok = CMD.wdata == csum(s_reg.buffer, BUF_BYTES);
      chal_sum_ok = CMD.wdata == csum(s_reg.buffer, CHAL_BYTES);
      {a, b, c, d, e} = s_reg.work;
      w0 = s_reg.w[511:480];
      wn = rol(s_reg.w[95:64] ^ s_reg.w[255:224] ^ s_reg.w[447:416] ^ w0, 1);
      if (s_reg.rnd < 7'd20) begin
         f = (b & c) | (~b & d);
         k = K0;
      end else if (s_reg.rnd < 7'd40) begin
         f = b ^ c ^ d;
         k = K1;
      end else if (s_reg.rnd < 7'd60) begin
         f = (b & c) | (b & d) | (c & d);
         k = K2;
      end else begin
         f = b ^ c ^ d;
         k = K3;
      end
      t = rol(a, 5) + f + e + k + w0;
      // chaining value plus this block's result, used on the last round
      h_sum = {s_reg.h[159:128] + t, s_reg.h[127:96] + a, s_reg.h[95:64] + rol(b, 30),
         s_reg.h[63:32] + c, s_reg.h[31:0] + d};

      s_next = s_reg;
      s_next.done = 1'b0;
      if (CMD.rd) begin
         if (CMD.addr == LOC_CHAL_CSUM) begin
            // inside the buffer window, yet a checksum slot never reads back
            s_next.rdata = 8'h00;
         end else if (in_buf) begin
            s_next.rdata = s_reg.buffer[bidx];
         end else if (CMD.addr == LOC_ACCESS) begin
            s_next.rdata = s_reg.access;
         end else if (CMD.addr == LOC_SUBCLASS) begin
            s_next.rdata = s_reg.subclass;
         end else if (CMD.addr == LOC_BLKSEL) begin
            s_next.rdata = s_reg.blksel;
         end else begin
            s_next.rdata = 8'h00;
         end
      end

      unique case (s_reg.st)
         ST_IDLE: begin
            // writes while hashing are dropped so the buffer stays coherent
            if (CMD.wr) begin
               if (CMD.addr == LOC_ACCESS) begin
                  s_next.access = CMD.wdata;
               end else if (CMD.addr == LOC_SUBCLASS) begin
                  s_next.subclass = CMD.wdata;
               end else if (CMD.addr == LOC_BLKSEL) begin
                  s_next.blksel = CMD.wdata;
               end else if (CMD.addr == LOC_CHAL_CSUM && auth_mode) begin
                  // this slot lies in the buffer window; in a query it must not be stored
                  if (chal_sum_ok) begin
                     s_next.h = SHA_IV;
                     s_next.blk = 2'd0;
                     s_next.st = ST_LOAD;
                  end
               end else if (in_buf && (key_mode || auth_mode)) begin
                  s_next.buffer[bidx] = CMD.wdata;
               end else if (CMD.addr == LOC_BLK_CSUM && key_mode && key_sum_ok) begin
                  for (int i = 0; i < KEY_BYTES; i++) begin
                     s_next.key[127-8*i -: 8] = s_reg.buffer[KEY_OFS+i];
                  end
               end
            end
         end
         ST_LOAD: begin
            // one load cycle per block, then the rounds
            s_next.w = msg_block(s_reg.blk, s_reg.key, s_reg.buffer, s_reg.inner);
            s_next.work = s_reg.h;
            s_next.rnd = 7'd0;
            s_next.st = ST_RUN;
         end
         ST_RUN: begin
            s_next.work = {t, a, rol(b, 30), c, d};
            s_next.w = {s_reg.w[479:0], wn};
            s_next.rnd = s_reg.rnd + 7'd1;
            if (s_reg.rnd == ROUND_LAST) begin
               s_next.blk = s_reg.blk + 2'd1;
               s_next.st = ST_LOAD;
               s_next.h = h_sum;
               if (s_reg.blk == 2'd1) begin
                  s_next.inner = h_sum; // inner hash done, restart for outer
                  s_next.h = SHA_IV;
               end else if (s_reg.blk == 2'd3) begin
                  for (int i = 0; i < CHAL_BYTES; i++) begin
                     s_next.buffer[i] = h_sum[159-8*i -: 8];
                  end
                  s_next.done = 1'b1;
                  s_next.st = ST_IDLE;
               end
            end
         end
         default: begin
            // a corrupted state code falls back to idle and drops the run
            s_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s_reg <= '{st: ST_IDLE, buffer: '0, key: KEY_DEFAULT, access: ACCESS_RST,
            subclass: SUBCLASS_RST, blksel: BLKSEL_RST, rdata: 8'h00, done: 1'b0,
            h: SHA_IV, work: '0, w: '0, rnd: 7'd0, blk: 2'd0, inner: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   // registered read data answers one cycle after the strobe
   assign CMD_RDATA = s_reg.rdata;
   assign BUSY = s_reg.st != ST_IDLE;
   assign DIGEST_READY = s_reg.done;
endmodule : hcr_responder
`default_nettype wire

// file: verification/hcr_host_model.sv
/* Host model: byte writes and reads on the command port.
   Assumes the responder samples the command on the rising clock edge. */
`default_nettype none
module hcr_host_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output var hcr_pkg::hcr_cmd_s cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cmd = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cmd <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      // released lines must not keep the old value
      cmd <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      cmd <= '{1'b0, 1'b1, a, ~a};
      @(posedge clk);
      cmd <= '{1'b0, 1'b0, ~a, a};
      // data launched at the taking edge stands until the next read
      @(posedge clk);
      d = rdata;
   endtask : rd
endmodule : hcr_host_model
`default_nettype wire

// file: verification/hcr_responder_monitor.sv
/* Checker of the digest responder: start, busy length, completion pulse, reads.
   Assumes it sees only the responder's ports, bound below. */
`default_nettype none
module hcr_responder_monitor (
   input wire logic CLK,
   input wire logic RST,
   input wire hcr_pkg::hcr_cmd_s CMD,
   input wire logic UNLOCKED,
   input wire logic [7:0] CMD_RDATA,
   input wire logic BUSY,
   input wire logic DIGEST_READY
);
   timeunit 1ns;
   timeprecision 1ps;
   import hcr_pkg::*;
   logic [9:0] busy_cnt_reg;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // 324 edges far exceeds any repetition count, so count them
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         busy_cnt_reg <= 10'h000;
      end else begin
         busy_cnt_reg <= BUSY ? busy_cnt_reg + 10'h001 : 10'h000;
      end
   end
   a_busy_length: assert property ($fell(BUSY) |-> busy_cnt_reg == 10'h144)
      else $error("busy length wrong");
   a_start_after_csum: assert property ($rose(BUSY) |->
      $past(CMD.wr) && $past(CMD.addr) == LOC_CHAL_CSUM)
      else $error("hash started without checksum");
   a_busy_holds: assert property ($rose(BUSY) |=> BUSY [*8])
      else $error("busy dropped early");
   a_ready_ends_busy: assert property (DIGEST_READY |-> !BUSY && $past(BUSY))
      else $error("ready outside busy end");
   a_fall_gives_ready: assert property ($fell(BUSY) |-> DIGEST_READY)
      else $error("busy fell without ready");
   a_ready_single: assert property (DIGEST_READY |=> !DIGEST_READY)
      else $error("ready longer than a cycle");
   a_rdata_holds: assert property (!$past(CMD.rd) |-> $stable(CMD_RDATA))
      else $error("read data moved");
   a_csum_reads_zero: assert property ($past(CMD.rd) && ($past(CMD.addr) == LOC_CHAL_CSUM
      || $past(CMD.addr) == LOC_BLK_CSUM) |-> CMD_RDATA == 8'h00)
      else $error("checksum location readable");
endmodule : hcr_responder_monitor
bind hcr_responder hcr_responder_monitor i_mon (.CLK(CLK), .RST(RST), .CMD(CMD),
   .UNLOCKED(UNLOCKED), .CMD_RDATA(CMD_RDATA), .BUSY(BUSY), .DIGEST_READY(DIGEST_READY));
`default_nettype wire

// file: verification/hcr_responder_tb.sv
/* Bench of the digest responder: queries, key programming, lock refusal.
   Assumes the host model drives the command port. */
`default_nettype none
module hcr_responder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hcr_pkg::*;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
   $display("mismatch %0t got %h", $time, a); end end
   logic clk = 1'b0, rst = 1'b1, unlocked = 1'b1, busy, ready;
   logic [7:0] rdata, b;
   logic [31:0] seed = 32'h025AA4B7;
   logic [127:0] k;
   logic [19:0][7:0] chal, dg, d1;
   hcr_cmd_s cmd;
   int n_fail = 0, compares = 0, cyc = 0, i;
   hcr_host_model i_host (.clk(clk), .rdata(rdata), .cmd(cmd));
   hcr_responder i_dut (.CLK(clk), .RST(rst), .CMD(cmd), .UNLOCKED(unlocked),
      .CMD_RDATA(rdata), .BUSY(busy), .DIGEST_READY(ready));
   always #2 clk = ~clk;
   function automatic logic [7:0] rnd8();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction : rnd8
   // reference compression, written with a full schedule array
   function automatic logic [159:0] sha_blk(input logic [159:0] hv, input logic [511:0] m);
      logic [31:0] w[80];
      logic [31:0] a, b, c, d, e, f, kk, tmp;
      for (int j = 0; j < 80; j++) begin
         if (j < 16) begin
            w[j] = m[511 - 32 * j -: 32];
         end else begin
            tmp = w[j - 3] ^ w[j - 8] ^ w[j - 14] ^ w[j - 16];
            w[j] = {tmp[30:0], tmp[31]};
         end
      end
      {a, b, c, d, e} = hv;
      for (int j = 0; j < 80; j++) begin
         if (j < 20) begin
            f = (b & c) | (~b & d);
            kk = K0;
         end else if (j < 40) begin
            f = b ^ c ^ d;
            kk = K1;
         end else if (j < 60) begin
            f = (b & c) | (b & d) | (c & d);
            kk = K2;
         end else begin
            f = b ^ c ^ d;
            kk = K3;
         end
         tmp = {a[26:0], a[31:27]} + f + e + kk + w[j];
         e = d;
         d = c;
         c = {b[1:0], b[31:2]};
         b = a;
         a = tmp;
      end
      return {hv[159:128] + a, hv[127:96] + b, hv[95:64] + c, hv[63:32] + d, hv[31:0] + e};
   endfunction : sha_blk
   // keyed digest of a challenge, byte j at location 0x40 + j
   function automatic logic [19:0][7:0] hmac(input logic [127:0] key,
         input logic [19:0][7:0] msg);
      logic [511:0] kb;
      logic [511:0] tail;
      logic [159:0] hv;
      logic [19:0][7:0] r;
      kb = {key, 384'h0};
      tail = '0;
      for (int j = 0; j < CHAL_BYTES; j++) begin
         tail[511 - 8 * j -: 8] = msg[j];
      end
      tail[351:344] = 8'h80;
      tail[63:0] = 64'((64 + CHAL_BYTES) * 8);
      hv = sha_blk(sha_blk(SHA_IV, kb ^ {64{IPAD}}), tail);
      hv = sha_blk(sha_blk(SHA_IV, kb ^ {64{OPAD}}), {hv, tail[351:0]});
      for (int j = 0; j < CHAL_BYTES; j++) begin
         r[j] = hv[159 - 8 * j -: 8];
      end
      return r;
   endfunction : hmac
   task automatic stop_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic query();
      logic [7:0] s;
      int n;
      s = 8'h00;
      for (n = 0; n < CHAL_BYTES; n++) begin
         i_host.wr(LOC_BUF_FIRST + 8'(n), chal[n]);
         s += chal[n];
      end
      i_host.wr(LOC_CHAL_CSUM, s);
      repeat (2) @(negedge clk);
      `CHK(busy, 1'b0)
      i_host.wr(LOC_CHAL_CSUM, ~s);
      for (n = 0; n < 400 && ready !== 1'b1; n++) begin
         @(negedge clk);
      end
      // four blocks of one load and 80 rounds, seen on the negedge after
      `CHK(n, 4 * (int'(ROUND_LAST) + 2) + 1)
      for (n = 0; n < CHAL_BYTES; n++) begin
         i_host.rd(LOC_BUF_FIRST + 8'(n), dg[n]);
      end
   endtask : query
   task automatic prog(input logic bad);
      logic [7:0] s, v;
      int n;
      s = 8'h00;
      i_host.wr(LOC_ACCESS, ACCESS_KEY);
      i_host.wr(LOC_SUBCLASS, SUBCLASS_KEY);
      i_host.wr(LOC_BLKSEL, BLOCK_KEY);
      for (n = 0; n < BUF_BYTES; n++) begin
         v = rnd8();
         if (n >= KEY_OFS && n < KEY_OFS + KEY_BYTES) begin
            v = k[127 - 8 * (n - KEY_OFS) -: 8];
         end
         i_host.wr(LOC_BUF_FIRST + 8'(n), v);
         s += v;
      end
      i_host.wr(LOC_BLK_CSUM, bad ? s : ~s);
   endtask : prog
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      i_host.rd(LOC_BUF_FIRST, b);
      `CHK(b, 8'h00)
      i_host.rd(LOC_BLK_CSUM, b);
      `CHK(b, 8'h00)
      for (i = 0; i < CHAL_BYTES; i++) begin
         chal[i] = rnd8();
      end
      for (i = 0; i < KEY_BYTES; i++) begin
         k = {k[119:0], rnd8()};
      end
      i_host.wr(LOC_ACCESS, ACCESS_AUTH);
      i_host.rd(LOC_ACCESS, b);
      `CHK(b, ACCESS_AUTH)
      query();
      d1 = dg;
      `CHK(dg != chal, 1'b1)
      `CHK(dg, hmac(KEY_DEFAULT, chal))
      query();
      `CHK(dg, d1)
      @(posedge clk) unlocked <= 1'b0;
      prog(1'b0);
      i_host.wr(LOC_BLKSEL, BLOCK_AUTH_LOCKED);
      query();
      `CHK(dg, d1)
      @(posedge clk) unlocked <= 1'b1;
      prog(1'b1);
      i_host.wr(LOC_ACCESS, ACCESS_AUTH);
      query();
      `CHK(dg, d1)
      prog(1'b0);
      i_host.wr(LOC_ACCESS, ACCESS_AUTH);
      query();
      `CHK(dg != d1, 1'b1)
      `CHK(dg, hmac(k, chal))
      stop_test();
   end
endmodule : hcr_responder_tb
`default_nettype wire
